// File: design/pftp_cfg.svh
// Constants for the pulse-driven fuse trim programmer: offsets, field
// positions, reset values and pulse counts, all as macros.
// Assumes inclusion by bare name from the package and the bench files.
//
// Summary of operation
// R01: Power-up loads fuses, intact zero, blown one
// R02: After power-up the machine sits in initial
// R03: Programmer power-cycles before each blow or lock
// R04: Trial values persist until supply is cycled
// R05: High pulse in initial enters mode selection
// R06: Low pulse count picks trial, blow, lock
// R07: High pulse after trial/blow enters register selection
// R08: Low pulse count picks register; four is TC
// R09: Entering bitfield selection clears intact bits
// R10: Each low pulse increments selected code
// R11: Trial code applies to trim output immediately
// R12: Trial exit returns to mode selection, keeps value
// R13: Blow exit blows set bits, returns mode selection
// R14: Programmer sets one bitfield per blow sequence
// R15: Blown bits never clear; value ORs fuses
// R16: Blowing allowed until lock bit is blown
// R17: Lock mode skips register selection, blows lock
// R18: Programmer waits for high pulse decay
// R19: Programmer follows recommended register order
// R20: Clamp register may be programmed anytime
// R21: Coarse two-bit registers wrap to 00
// R22: Lock is register 0 bitfield 1
// R23: Pulses classified by thresholds, one event each
`ifndef PFTP_CFG_SVH
`define PFTP_CFG_SVH

// Wishbone byte offsets
`define PFTP_ADR_CTRL     8'h00
`define PFTP_ADR_THRESH   8'h04
`define PFTP_ADR_STATUS   8'h08
`define PFTP_ADR_TRIM     8'h0c
`define PFTP_ADR_FUSE     8'h10

// Reset values
`define PFTP_CTRL_RST     1'h1
`define PFTP_THR_LO_RST   8'h40
`define PFTP_THR_HI_RST   8'hc0

// Mode selection pulse counts
`define PFTP_CNT_TRIAL    4'h1
`define PFTP_CNT_BLOW     4'h2
`define PFTP_CNT_LOCK     4'h3

// Register numbers chosen by low pulse count
`define PFTP_REG_QVOF     4'h1
`define PFTP_REG_QVOC     4'h2
`define PFTP_REG_SENF     4'h3
`define PFTP_REG_TC       4'h4
`define PFTP_REG_SENC     4'h5
`define PFTP_REG_CLAMP    4'h6
`define PFTP_REG_POL      4'h7

// Field masks in the 32-bit trim word
`define PFTP_MSK_QVOF     32'h0000_01ff
`define PFTP_MSK_QVOC     32'h0000_0600
`define PFTP_MSK_SENF     32'h0007_f800
`define PFTP_MSK_TC       32'h00f8_0000
`define PFTP_MSK_SENC     32'h0300_0000
`define PFTP_MSK_CLAMP    32'h0c00_0000
`define PFTP_MSK_POL      32'h1000_0000
`define PFTP_MSK_LOCK     32'h2000_0000

// Field least significant bits
`define PFTP_LSB_QVOF     5'd0
`define PFTP_LSB_QVOC     5'd9
`define PFTP_LSB_SENF     5'd11
`define PFTP_LSB_TC       5'd19
`define PFTP_LSB_SENC     5'd24
`define PFTP_LSB_CLAMP    5'd26
`define PFTP_LSB_POL      5'd28
`define PFTP_LSB_LOCK     5'd29

// Two-bit registers wrap when reaching this code
`define PFTP_COARSE_WRAP  32'h0000_0003

`endif

// File: design/pftp_pkg.sv
// Types shared by the fuse trim programmer modules.
// Assumes the constants header is on the include path.
`include "pftp_cfg.svh"

package pftp_pkg;

	// Programming sequence states
	typedef enum logic [1:0] {
		PFTP_ST_INIT    = 2'b00,
		PFTP_ST_MODESEL = 2'b01,
		PFTP_ST_REGSEL  = 2'b10,
		PFTP_ST_BITSEL  = 2'b11
	} pftp_state_t;

	// Selected programming mode
	typedef enum logic [1:0] {
		PFTP_MD_NONE  = 2'b00,
		PFTP_MD_TRIAL = 2'b01,
		PFTP_MD_BLOW  = 2'b10,
		PFTP_MD_LOCK  = 2'b11
	} pftp_mode_t;

	// One-cycle pulse events from the classifier
	typedef struct packed {
		logic high_level_pulse;
		logic low_level_pulse;
	} pftp_evt_t;

	// Fuse blow request toward the fuse array
	typedef struct packed {
		logic        valid;
		logic [31:0] mask;
	} pftp_blow_t;

endpackage

// File: design/pftp_pulse_detect.sv
// Pulse classifier for the output pin level.
// Assumes a digitised pin level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module pftp_pulse_detect
	import pftp_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst,
	input  wire logic         i_clk_en,
	input  wire logic [W-1:0] i_level,
	input  wire logic [W-1:0] i_thr_lo,
	input  wire logic [W-1:0] i_thr_hi,
	output pftp_evt_t         o_evt
);

	logic [W-1:0] s1_q, s2_q, s3_q;   // Synchroniser stages
	logic [W-1:0] lvl_q, lvl_d;       // Filtered level
	logic         act_q, act_d;       // Pulse in progress
	logic         peak_q, peak_d;     // High threshold reached
	pftp_evt_t    evt_q, evt_d;       // Registered events

	// Per bit: accept a change once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_filt
			always_comb begin
				lvl_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : lvl_q[gi];
			end
		end
	endgenerate

	// Classify on falling edge below low threshold
	always_comb begin
		act_d  = act_q;
		peak_d = peak_q;
		evt_d  = '0;
		if (!act_q) begin
			// Start of a pulse
			if (lvl_q > i_thr_lo) begin
				act_d  = 1'b1;
				peak_d = (lvl_q > i_thr_hi);
			end
		end else if (lvl_q <= i_thr_lo) begin
			// Pulse ended: one event only
			act_d                  = 1'b0;
			peak_d                 = 1'b0;
			evt_d.high_level_pulse = peak_q; // R23
			evt_d.low_level_pulse  = !peak_q; // R23
		end else if (lvl_q > i_thr_hi) begin
			// Remember the pulse went high
			peak_d = 1'b1;
		end
	end

	// Register stage
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			lvl_q  <= '0;
			act_q  <= 1'b0;
			peak_q <= 1'b0;
			evt_q  <= '0;
		end else if (i_clk_en) begin
			s1_q   <= i_level;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			lvl_q  <= lvl_d;
			act_q  <= act_d;
			peak_q <= peak_d;
			evt_q  <= evt_d;
		end
	end

	assign o_evt = evt_q;

endmodule

`default_nettype wire

// File: design/pftp_top.sv
// Fuse trim programmer: pulse-driven mode machine, trim word, fuse
// shadow and a classic Wishbone slave for control and status.
// Assumes i_rst is the supply power-on reset and i_fuse_sense is the
// steady sense output of the nonvolatile fuse array.
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pftp_top
	import pftp_pkg::*;
#(
	parameter int LW = 8
) (
	input  wire logic          i_sys_clk,
	input  wire logic          i_rst,
	input  wire logic          i_clk_en,
	input  wire logic [LW-1:0] i_output_pin,
	input  wire logic [31:0]   i_fuse_sense,
	input  wire logic          i_wb_cyc,
	input  wire logic          i_wb_stb,
	input  wire logic          i_wb_we,
	input  wire logic [7:0]    i_wb_adr,
	input  wire logic [3:0]    i_wb_sel,
	input  wire logic [31:0]   i_wb_dat,
	output logic [31:0]        o_wb_dat,
	output logic               o_wb_ack,
	output logic [31:0]        o_trim,
	output pftp_blow_t         o_blow
);

	// Pulse events from the classifier
	pftp_evt_t   evt;

	// Sequence state
	pftp_state_t st_q, st_d;          // Machine state
	pftp_mode_t  md_q, md_d;          // Chosen mode
	logic [3:0]  cnt_q, cnt_d;        // Low pulse counter
	logic [3:0]  rsel_q, rsel_d;      // Selected register
	logic [31:0] trim_q, trim_d;      // Live trim word
	logic [31:0] fuse_q, fuse_d;      // Blown fuse shadow
	logic        ld_q, ld_d;          // Fuse load pending
	pftp_blow_t  blow_q, blow_d;      // Blow request

	// Bus registers
	logic        en_q, en_d;          // Programming enable
	logic [7:0]  tlo_q, tlo_d;        // Low threshold
	logic [7:0]  thi_q, thi_d;        // High threshold
	logic        ack_q, ack_d;        // Bus acknowledge
	logic [31:0] rdat_q, rdat_d;      // Read data

	// Derived values
	logic        locked;              // Lock fuse blown
	logic        hp;                  // Usable high pulse
	logic        lp;                  // Usable low pulse
	logic [31:0] fmask;               // Selected field mask
	logic [4:0]  flsb;                // Selected field lsb
	logic        coarse;              // Selected field wraps at 3
	logic [31:0] fval;                // Field value shifted down
	logic [31:0] finc;                // Incremented field value
	logic        bus_req;             // New bus request

	// Pin pulse classifier
	pftp_pulse_detect #(
		.W (LW)
	) u_detect (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_clk_en  (i_clk_en),
		.i_level   (i_output_pin),
		.i_thr_lo  (tlo_q[LW-1:0]),
		.i_thr_hi  (thi_q[LW-1:0]),
		.o_evt     (evt)
	);

	// Lock state read from the shadow
	assign locked = |(fuse_q & `PFTP_MSK_LOCK); // R22

	// Events only count once fuses are loaded and enabled
	assign hp = evt.high_level_pulse && en_q && !ld_q;
	assign lp = evt.low_level_pulse && en_q && !ld_q;

	// Field decode for the selected register
	always_comb begin
		fmask  = 32'h0000_0000;
		flsb   = 5'd0;
		coarse = 1'b0;
		if (md_q == PFTP_MD_LOCK) begin
			// Lock mode targets the lock bit only
			fmask = `PFTP_MSK_LOCK; // R17
			flsb  = `PFTP_LSB_LOCK;
		end else begin
			unique case (rsel_q)
				`PFTP_REG_QVOF: begin
					fmask = `PFTP_MSK_QVOF;
					flsb  = `PFTP_LSB_QVOF;
				end
				`PFTP_REG_QVOC: begin
					fmask  = `PFTP_MSK_QVOC;
					flsb   = `PFTP_LSB_QVOC;
					coarse = 1'b1;
				end
				`PFTP_REG_SENF: begin
					fmask = `PFTP_MSK_SENF;
					flsb  = `PFTP_LSB_SENF;
				end
				`PFTP_REG_TC: begin
					// Temperature coefficient on four pulses
					fmask = `PFTP_MSK_TC; // R08
					flsb  = `PFTP_LSB_TC;
				end
				`PFTP_REG_SENC: begin
					fmask  = `PFTP_MSK_SENC;
					flsb   = `PFTP_LSB_SENC;
					coarse = 1'b1;
				end
				`PFTP_REG_CLAMP: begin
					// Clamp has no ordering constraint
					fmask  = `PFTP_MSK_CLAMP; // R20
					flsb   = `PFTP_LSB_CLAMP;
					coarse = 1'b1;
				end
				`PFTP_REG_POL: begin
					fmask = `PFTP_MSK_POL;
					flsb  = `PFTP_LSB_POL;
				end
				default: begin
					// No register selected
					fmask = 32'h0000_0000;
				end
			endcase
		end
	end

	// Increment the selected field with wrap
	always_comb begin
		fval = (trim_q & fmask) >> flsb;
		finc = fval + 32'h0000_0001; // R10
		if (coarse && finc == `PFTP_COARSE_WRAP) begin
			// Two-bit coarse codes go back to 00
			finc = 32'h0000_0000; // R21
		end
	end

	// Sequence next-state logic
	always_comb begin
		st_d   = st_q;
		md_d   = md_q;
		cnt_d  = cnt_q;
		rsel_d = rsel_q;
		trim_d = trim_q;
		fuse_d = fuse_q;
		ld_d   = ld_q;
		blow_d = '0;
		if (ld_q) begin
			// First enabled cycle after power-up: load fuses
			trim_d = i_fuse_sense; // R01
			fuse_d = i_fuse_sense; // R01
			ld_d   = 1'b0;
			st_d   = PFTP_ST_INIT; // R02
		end else begin
			unique case (st_q)
				PFTP_ST_INIT: begin
					// Wait for first high pulse
					if (hp) begin
						st_d  = PFTP_ST_MODESEL; // R05
						cnt_d = 4'h0;
						md_d  = PFTP_MD_NONE;
					end
				end
				PFTP_ST_MODESEL: begin
					if (lp) begin
						// Count mode pulses, saturating
						cnt_d = (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1; // R06
					end else if (hp) begin
						cnt_d = 4'h0;
						unique case (cnt_q)
							`PFTP_CNT_TRIAL: begin
								md_d = PFTP_MD_TRIAL; // R06
								st_d = PFTP_ST_REGSEL; // R07
							end
							`PFTP_CNT_BLOW: begin
								md_d = PFTP_MD_BLOW; // R06
								st_d = PFTP_ST_REGSEL; // R07
							end
							`PFTP_CNT_LOCK: begin
								// Straight to bitfield selection
								md_d   = PFTP_MD_LOCK; // R06
								st_d   = PFTP_ST_BITSEL; // R17
								trim_d = (trim_q & ~`PFTP_MSK_LOCK)
									| (fuse_q & `PFTP_MSK_LOCK); // R09
							end
							default: begin
								// Bad count: stay in mode selection
								md_d = PFTP_MD_NONE;
							end
						endcase
					end
				end
				PFTP_ST_REGSEL: begin
					if (lp) begin
						// Count register pulses, saturating
						cnt_d = (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1; // R08
					end else if (hp) begin
						cnt_d  = 4'h0;
						rsel_d = cnt_q; // R08
						if (cnt_q >= `PFTP_REG_QVOF && cnt_q <= `PFTP_REG_POL) begin
							// Enter bitfield selection, keep blown bits only
							st_d = PFTP_ST_BITSEL; // R09
							unique case (cnt_q)
								`PFTP_REG_QVOF:  trim_d = (trim_q & ~`PFTP_MSK_QVOF)
									| (fuse_q & `PFTP_MSK_QVOF); // R09
								`PFTP_REG_QVOC:  trim_d = (trim_q & ~`PFTP_MSK_QVOC)
									| (fuse_q & `PFTP_MSK_QVOC); // R09
								`PFTP_REG_SENF:  trim_d = (trim_q & ~`PFTP_MSK_SENF)
									| (fuse_q & `PFTP_MSK_SENF); // R09
								`PFTP_REG_TC:    trim_d = (trim_q & ~`PFTP_MSK_TC)
									| (fuse_q & `PFTP_MSK_TC); // R09
								`PFTP_REG_SENC:  trim_d = (trim_q & ~`PFTP_MSK_SENC)
									| (fuse_q & `PFTP_MSK_SENC); // R09
								`PFTP_REG_CLAMP: trim_d = (trim_q & ~`PFTP_MSK_CLAMP)
									| (fuse_q & `PFTP_MSK_CLAMP); // R09
								default:         trim_d = (trim_q & ~`PFTP_MSK_POL)
									| (fuse_q & `PFTP_MSK_POL); // R09
							endcase
						end else begin
							// Unknown register: back to mode selection
							st_d = PFTP_ST_MODESEL;
						end
					end
				end
				PFTP_ST_BITSEL: begin
					if (lp) begin
						// Step the code; blown bits stay set
						trim_d = (trim_q & ~fmask)
							| ((finc << flsb) & fmask)
							| (fuse_q & fmask); // R15
					end else if (hp) begin
						// Leave bitfield selection
						st_d  = PFTP_ST_MODESEL; // R12
						cnt_d = 4'h0;
						if (md_q != PFTP_MD_TRIAL && !locked) begin
							// Blow every set bit of the selected field not yet blown
							blow_d.mask  = trim_q & fmask & ~fuse_q; // R13
							blow_d.valid = |(trim_q & fmask & ~fuse_q); // R16
							fuse_d       = fuse_q | (trim_q & fmask); // R15
						end
						md_d = PFTP_MD_NONE;
					end
				end
			endcase
		end
	end

	// Sequence registers; trim persists until power cycles
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q   <= PFTP_ST_INIT; // R02
			md_q   <= PFTP_MD_NONE;
			cnt_q  <= 4'h0;
			rsel_q <= 4'h0;
			trim_q <= 32'h0000_0000;
			fuse_q <= 32'h0000_0000;
			ld_q   <= 1'b1;
			blow_q <= '0;
		end else if (i_clk_en) begin
			st_q   <= st_d;
			md_q   <= md_d;
			cnt_q  <= cnt_d;
			rsel_q <= rsel_d;
			trim_q <= trim_d; // R04
			fuse_q <= fuse_d;
			ld_q   <= ld_d;
			blow_q <= blow_d;
		end
	end

	// Trial values drive the analog trims directly
	assign o_trim = trim_q; // R11
	assign o_blow = blow_q;

	// New request when strobed and not already answered
	assign bus_req = i_wb_cyc && i_wb_stb && !ack_q;

	// Bus next-state logic
	always_comb begin
		en_d   = en_q;
		tlo_d  = tlo_q;
		thi_d  = thi_q;
		ack_d  = bus_req;
		rdat_d = 32'h0000_0000;
		if (bus_req) begin
			if (i_wb_we) begin
				// Writes with byte lanes
				unique case (i_wb_adr)
					`PFTP_ADR_CTRL: begin
						if (i_wb_sel[0]) en_d = i_wb_dat[0];
					end
					`PFTP_ADR_THRESH: begin
						if (i_wb_sel[0]) tlo_d = i_wb_dat[7:0];
						if (i_wb_sel[1]) thi_d = i_wb_dat[15:8];
					end
					default: begin
						// Read-only or unmapped: ignored
						en_d = en_q;
					end
				endcase
			end else begin
				// Reads
				unique case (i_wb_adr)
					`PFTP_ADR_CTRL:   rdat_d = {31'h0000_0000, en_q};
					`PFTP_ADR_THRESH: rdat_d = {16'h0000, thi_q, tlo_q};
					`PFTP_ADR_STATUS: rdat_d = {23'h00_0000, locked, rsel_q,
						md_q, st_q};
					`PFTP_ADR_TRIM:   rdat_d = trim_q;
					`PFTP_ADR_FUSE:   rdat_d = fuse_q;
					default:          rdat_d = 32'h0000_0000;
				endcase
			end
		end
	end

	// Bus registers
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			en_q   <= `PFTP_CTRL_RST;
			tlo_q  <= `PFTP_THR_LO_RST;
			thi_q  <= `PFTP_THR_HI_RST;
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else if (i_clk_en) begin
			en_q   <= en_d;
			tlo_q  <= tlo_d;
			thi_q  <= thi_d;
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;

endmodule

`default_nettype wire

// File: tb/pftp_top_props.sv
// Port checker for the fuse trim programmer top level.
// Assumes one clock domain and binding onto every pftp_top instance.
`timescale 1ns/1ps
`default_nettype none
`include "pftp_cfg.svh"

module pftp_top_props
	import pftp_pkg::*;
#(
	parameter int LW = 8
) (
	input wire logic          i_sys_clk,
	input wire logic          i_rst,
	input wire logic          i_clk_en,
	input wire logic [LW-1:0] i_output_pin,
	input wire logic [31:0]   i_fuse_sense,
	input wire logic          i_wb_cyc,
	input wire logic          i_wb_stb,
	input wire logic          i_wb_we,
	input wire logic [7:0]    i_wb_adr,
	input wire logic [3:0]    i_wb_sel,
	input wire logic [31:0]   i_wb_dat,
	input wire logic [31:0]   o_wb_dat,
	input wire logic          o_wb_ack,
	input wire logic [31:0]   o_trim,
	input wire pftp_blow_t    o_blow
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	// Request taken at this edge
	logic req_w;
	assign req_w = i_wb_cyc && i_wb_stb && !o_wb_ack && i_clk_en;

	a_ack_after_req: assert property (req_w |=> o_wb_ack)
		else $error("bus request not answered one cycle later");
	a_ack_single: assert property ($rose(o_wb_ack) |=> !o_wb_ack)
		else $error("bus answer longer than one cycle");
	a_dat_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
		else $error("read data not zero outside answer");
	a_trim_reset_zero: assert property ($fell(i_rst) |-> o_trim == 32'h0 && !o_blow.valid)
		else $error("trim or blow not cleared by power-on");
	a_fuse_in_trim: assert property (!$past(i_rst) |-> (i_fuse_sense & ~o_trim) == 32'h0)
		else $error("blown bit missing from trim word");
	a_blow_single: assert property (o_blow.valid |=> !o_blow.valid)
		else $error("blow request longer than one cycle");
	a_blow_set_bits: assert property (o_blow.valid |-> (o_blow.mask & ~o_trim) == 32'h0)
		else $error("blow mask holds bits not set in trim");
	a_blow_new_only: assert property (o_blow.valid |-> (o_blow.mask & i_fuse_sense) == 32'h0)
		else $error("blow mask repeats a blown bit");
	a_no_blow_locked: assert property (
		(i_fuse_sense & `PFTP_MSK_LOCK) != 32'h0 |-> !o_blow.valid)
		else $error("blow issued on a locked device");

	// Main scenarios reached
	c_blow: cover property (o_blow.valid);
	c_lock: cover property (o_blow.valid && o_blow.mask == `PFTP_MSK_LOCK);
	c_read: cover property (o_wb_ack && o_wb_dat != 32'h0);
endmodule

bind pftp_top pftp_top_props #(.LW(LW)) i_props (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_output_pin(i_output_pin),
	.i_fuse_sense(i_fuse_sense), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
	.i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
	.o_wb_ack(o_wb_ack), .o_trim(o_trim), .o_blow(o_blow)
);
`default_nettype wire

// File: tb/pftp_station.sv
// Programming station model: pin pulses and the nonvolatile fuse array.
// Assumes the bench cycles power by its own reset and calls the tasks.
`timescale 1ns/1ps
`default_nettype none

module pftp_station
	import pftp_pkg::*;
#(
	parameter int LW = 8
) (
	input  wire logic       i_sys_clk,
	input  wire pftp_blow_t i_blow,
	output logic [LW-1:0]   o_output_pin,
	output logic [31:0]     o_fuse_sense
);
	// Pin levels: idle below low threshold, pulses above it
	localparam logic [LW-1:0] IDLE_LVL = LW'(8'h25);
	int          n_blow;    // Blow requests seen
	logic [31:0] last_mask; // Mask of the latest blow

	initial begin
		o_output_pin = IDLE_LVL;
		o_fuse_sense = 32'h0;
		n_blow = 0;
		last_mask = 32'h0;
	end

	// Fuses accumulate and survive power cycles
	always @(posedge i_sys_clk) begin
		if (i_blow.valid === 1'b1) begin
			o_fuse_sense <= o_fuse_sense | i_blow.mask;
			n_blow <= n_blow + 1;
			last_mask <= i_blow.mask;
		end
	end

	// One pulse, then idle long enough for it to decay
	task automatic send(input bit hi);
		@(posedge i_sys_clk) o_output_pin <= hi ? LW'(8'hf0) : LW'(8'h9a);
		repeat (6) @(posedge i_sys_clk);
		o_output_pin <= IDLE_LVL;
		repeat (14) @(posedge i_sys_clk);
	endtask

	// Train of low-level pulses
	task automatic lows(input int n);
		repeat (n) send(1'b0);
	endtask
endmodule
`default_nettype wire

// File: tb/test_pulse_fuse_trim_programmer.sv
// Self-checking bench for the fuse trim programmer.
// Assumes the package, header, design and checker are compiled before.
`timescale 1ns/1ps
`default_nettype none
`include "pftp_cfg.svh"

module test_pulse_fuse_trim_programmer;
	import pftp_pkg::*;
	logic        clk, rst, clk_en, cyc, stb, we; // Bench-driven controls
	logic [7:0]  adr;                            // Bus address
	logic [3:0]  sel;                            // Byte lanes
	logic [31:0] wdat;                           // Write data
	wire logic [7:0]  pin;                       // Pin level from station
	wire logic [31:0] fuse, rdat, trim;          // Fuses, read data, trim word
	wire logic        ack;                       // Bus answer
	pftp_blow_t       blow;                      // Blow request
	int fails, n_compared, cycles;               // Counters

	pftp_top #(.LW(8)) i_dut (.i_sys_clk(clk), .i_rst(rst), .i_clk_en(clk_en),
		.i_output_pin(pin), .i_fuse_sense(fuse), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .o_trim(trim), .o_blow(blow));
	pftp_station #(.LW(8)) i_st (.i_sys_clk(clk), .i_blow(blow), .o_output_pin(pin),
		.o_fuse_sense(fuse));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			fails++;
			test_done();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// Classic single access, held until ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, input logic [3:0] s = 4'hf);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		chk("bus wait", 32'(n), 32'h2);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(what, q & m, exp);
	endtask

	// Supply off and on; fuses stay
	task automatic power_cycle;
		@(posedge clk) rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// Reset values, read-only and unmapped places, event enable
	task automatic t_regs;
		logic [31:0] q;
		rd_chk("ctrl", `PFTP_ADR_CTRL, 32'h1, 32'h1);
		rd_chk("thresh", `PFTP_ADR_THRESH, 32'hffff, 32'hc040);
		bus(1'b1, `PFTP_ADR_THRESH, 32'h0000_ff30, q, 4'h1);
		rd_chk("thresh lane0", `PFTP_ADR_THRESH, 32'hffff, 32'hc030);
		bus(1'b1, `PFTP_ADR_THRESH, 32'h0000_d0aa, q, 4'h2);
		rd_chk("thresh lane1", `PFTP_ADR_THRESH, 32'hffff, 32'hd030);
		bus(1'b1, `PFTP_ADR_THRESH, 32'h0000_c040, q);
		rd_chk("status", `PFTP_ADR_STATUS, 32'hff, 32'h0);
		rd_chk("trim", `PFTP_ADR_TRIM, 32'hffffffff, 32'h0);
		rd_chk("unmapped", 8'hf7, 32'hffffffff, 32'h0);
		bus(1'b1, `PFTP_ADR_TRIM, 32'hffffffff, q);
		rd_chk("trim ro", `PFTP_ADR_TRIM, 32'hffffffff, 32'h0);
		bus(1'b1, `PFTP_ADR_CTRL, 32'h0, q);
		i_st.send(1'b1);
		rd_chk("status off", `PFTP_ADR_STATUS, 32'hff, 32'h0);
		bus(1'b1, `PFTP_ADR_CTRL, 32'h1, q);
	endtask

	// Trial walk, increments, wrap, persistence
	task automatic t_trial;
		i_st.send(1'b1);
		i_st.lows(1);
		i_st.send(1'b1);
		i_st.lows(4);
		i_st.send(1'b1);
		rd_chk("status bitsel", `PFTP_ADR_STATUS, 32'hff, 32'h47);
		i_st.lows(5);
		chk("tc", trim & `PFTP_MSK_TC, 32'h5 << `PFTP_LSB_TC);
		// Clock enable low: a pulse sent now must be lost
		@(posedge clk) clk_en <= 1'b0;
		i_st.send(1'b0);
		@(posedge clk) clk_en <= 1'b1;
		chk("tc frozen", trim & `PFTP_MSK_TC, 32'h5 << `PFTP_LSB_TC);
		i_st.lows(1);
		chk("tc", trim & `PFTP_MSK_TC, 32'h6 << `PFTP_LSB_TC);
		i_st.send(1'b1);
		rd_chk("status modesel", `PFTP_ADR_STATUS, 32'hf, 32'h1);
		i_st.lows(1);
		i_st.send(1'b1);
		i_st.lows(2);
		i_st.send(1'b1);
		i_st.lows(2);
		chk("qvoc", trim & `PFTP_MSK_QVOC, 32'h2 << `PFTP_LSB_QVOC);
		i_st.lows(1);
		chk("qvoc wrap", trim & `PFTP_MSK_QVOC, 32'h0);
		chk("tc kept", trim & `PFTP_MSK_TC, 32'h6 << `PFTP_LSB_TC);
		i_st.send(1'b1);
		// Clamp tried after the TC and QVOC registers
		i_st.lows(1);
		i_st.send(1'b1);
		i_st.lows(6);
		i_st.send(1'b1);
		i_st.lows(1);
		chk("clamp", trim & `PFTP_MSK_CLAMP, 32'h1 << `PFTP_LSB_CLAMP);
		i_st.send(1'b1);
	endtask

	// Blow one selection sequence on the TC register; one new bit each time
	task automatic blow_tc(input int n);
		i_st.send(1'b1);
		i_st.lows(2);
		i_st.send(1'b1);
		i_st.lows(4);
		i_st.send(1'b1);
		i_st.lows(n);
		i_st.send(1'b1);
	endtask

	task automatic t_blow;
		int n0;
		n0 = i_st.n_blow;
		power_cycle();
		chk("trial lost", trim, 32'h0);
		blow_tc(4);
		chk("blow count", 32'(i_st.n_blow), 32'(n0 + 1));
		chk("blow mask", i_st.last_mask, 32'h0020_0000);
		power_cycle();
		chk("tc fused", trim & `PFTP_MSK_TC, 32'h4 << `PFTP_LSB_TC);
		blow_tc(2);
		chk("blow mask", i_st.last_mask, 32'h0010_0000);
		power_cycle();
		chk("tc or", trim & `PFTP_MSK_TC, 32'h6 << `PFTP_LSB_TC);
	endtask

	// Lock, then a refused blow
	task automatic t_lock;
		int n0;
		i_st.send(1'b1);
		i_st.lows(3);
		i_st.send(1'b1);
		i_st.lows(1);
		i_st.send(1'b1);
		chk("lock mask", i_st.last_mask, `PFTP_MSK_LOCK);
		rd_chk("locked", `PFTP_ADR_STATUS, 32'h10f, 32'h101);
		power_cycle();
		n0 = i_st.n_blow;
		blow_tc(1);
		chk("blow count", 32'(i_st.n_blow), 32'(n0));
	endtask

	task automatic test_done;
		$display("mismatches %0d, comparisons %0d", fails, n_compared);
		if (fails == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_regs();
		t_trial();
		t_blow();
		t_lock();
		test_done();
	end
endmodule
`default_nettype wire
